// ---- hw/mic_irq_ctrl.sv ----
// Lower interrupt groups, enables and vector selection for the core
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl
	import mic_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Special function register port
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Classic sources
	input  wire logic       pin_irq0_input,
	input  wire logic       pin_irq1_input,
	input  wire logic       pin0_edge_mode,
	input  wire logic       pin1_edge_mode,
	input  wire logic       timer0_overflow_flag,
	input  wire logic       timer1_overflow_flag,
	input  wire logic       timer2_overflow_flag,
	input  wire logic       timer2_external_flag,
	input  wire logic       serial1_tx_done_flag,
	input  wire logic       serial1_rx_done_flag,
	// Group ten sources
	input  wire logic       pin_irq3_input,
	input  wire logic       ref_leak_event,
	input  wire logic       zero_cross_event,
	input  wire logic       zero_cross_detect_enable,
	input  wire logic [2:0] euart_event_status,
	input  wire logic       euart_rx_irq_enable,
	input  wire logic       euart_tx_irq_enable,
	// Group eleven sources
	input  wire logic [3:0] capture_timer_event,
	input  wire logic       serial_iface_illegal_event,
	input  wire logic       serial_iface_tx_event,
	input  wire logic       comparator_event,
	// Power-down source
	input  wire logic       powerdown_event,
	// Core request port
	input  wire logic       irq_ack,
	output logic            irq_request,
	output logic      [7:0] irq_vector,
	output logic      [3:0] irq_number
);
	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [7:0] core_interrupt_enable;
	logic [4:0] ext_enable;
	logic       group10_flag;
	logic       group11_flag;
	logic       baud_double;
	logic       powerdown_flag;
	logic [7:0] group4_event_enable_reg;
	logic [7:0] group4_event_flag_reg;
	logic [7:0] group5_event_enable_reg;
	logic [7:0] group5_event_flag_reg;
	mic_state_t state;
	logic [3:0] held_slot;

	function automatic logic wr_hit(input logic       wr,
	                                input logic [7:0] addr,
	                                input logic [7:0] target);
		wr_hit = wr && (addr == target);
	endfunction

	function automatic logic [3:0] first_slot(input logic [8:0] pend);
		first_slot = 4'h0;
		for (int i = MIC_SLOTS - 1; i >= 0; i--) begin
			if (pend[i])
				first_slot = 4'(i);
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin catchers
	// ------------------------------------------------------------------
	logic [2:0] pin_level;
	logic [2:0] pin_mode;
	logic [2:0] pin_clear;
	logic [2:0] pin_fall;
	logic [2:0] pin_req;

	assign pin_level = {pin_irq3_input, pin_irq1_input, pin_irq0_input};
	assign pin_mode  = {1'b1, pin1_edge_mode, pin0_edge_mode};
	// Pin 3 only feeds a sticky group flag, so its latch is never used
	assign pin_clear[0] = (state == MIC_OFFER) && irq_ack
		&& (held_slot == 4'h0);
	assign pin_clear[1] = (state == MIC_OFFER) && irq_ack
		&& (held_slot == 4'h2);
	assign pin_clear[2] = 1'b1;

	generate
		for (genvar p = 0; p < 3; p++) begin : g_pin
			mic_pin_catch u_catch (
				.core_clk   (core_clk),
				.rst_n      (rst_n),
				.pin_level  (pin_level[p]),
				.edge_mode  (pin_mode[p]),
				.clear_req  (pin_clear[p]),
				.fall_pulse (pin_fall[p]),
				.request    (pin_req[p])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Peripheral event sets
	// ------------------------------------------------------------------
	logic       euart_event;
	logic [7:0] g4_set;
	logic [7:0] g5_set;

	assign euart_event = (euart_event_status[0] & euart_rx_irq_enable)
		| (euart_event_status[1] & euart_tx_irq_enable)
		| (euart_event_status[2] & euart_rx_irq_enable); // [R5]
	assign g4_set = {1'b0, euart_event,
		zero_cross_event & zero_cross_detect_enable, // [R4]
		ref_leak_event, pin_fall[2], 3'b000}; // [R4]
	assign g5_set = {1'b0, comparator_event, serial_iface_tx_event,
		serial_iface_illegal_event, capture_timer_event}; // [R2] [R3]

	// ------------------------------------------------------------------
	// Register writes; hardware sets win over software clears
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			core_interrupt_enable <= MIC_RST_REG;
		else if (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_CORE_EN))
			core_interrupt_enable <= sfr_wdata;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_enable  <= 5'h00;
			baud_double <= 1'b0;
		end else begin
			if (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_EXT_EN))
				ext_enable <= sfr_wdata[4:0];
			if (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_EXT_CTRL))
				baud_double <= sfr_wdata[MIC_BAUD_DBL_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			group4_event_enable_reg <= MIC_RST_REG;
			group5_event_enable_reg <= MIC_RST_REG;
		end else begin
			if (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_G4_EN))
				group4_event_enable_reg <= sfr_wdata;
			if (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_G5_EN))
				group5_event_enable_reg <= sfr_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			group4_event_flag_reg <= MIC_RST_REG;
			group5_event_flag_reg <= MIC_RST_REG;
		end else begin
			group4_event_flag_reg <= (wr_hit(sfr_wr, sfr_addr,
				MIC_ADDR_G4_FLAG) ? sfr_wdata : group4_event_flag_reg)
				| g4_set; // [R4] [R5]
			group5_event_flag_reg <= (wr_hit(sfr_wr, sfr_addr,
				MIC_ADDR_G5_FLAG) ? sfr_wdata : group5_event_flag_reg)
				| g5_set; // [R2] [R3]
		end
	end

	logic group10_req;
	logic group11_req;
	assign group10_req = |(group4_event_flag_reg
		& group4_event_enable_reg); // [R15]
	assign group11_req = |(group5_event_flag_reg
		& group5_event_enable_reg); // [R15]

	// Group flags stay up until software writes them low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			group10_flag   <= 1'b0;
			group11_flag   <= 1'b0;
			powerdown_flag <= 1'b0;
		end else begin
			group10_flag <= (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_EXT_FLAG)
				? sfr_wdata[MIC_G10_FLAG_BIT] : group10_flag)
				| group10_req;
			group11_flag <= (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_EXT_FLAG)
				? sfr_wdata[MIC_G11_FLAG_BIT] : group11_flag)
				| group11_req; // [R14] [R1]
			powerdown_flag <= (wr_hit(sfr_wr, sfr_addr, MIC_ADDR_EXT_CTRL)
				? sfr_wdata[MIC_PD_FLAG_BIT] : powerdown_flag)
				| powerdown_event; // [R13]
		end
	end

	// ------------------------------------------------------------------
	// Pending requests in polling order
	// ------------------------------------------------------------------
	logic       ga;
	logic [8:0] src;
	logic [8:0] en;
	logic [8:0] pend;

	assign ga  = core_interrupt_enable[MIC_GLOBAL_EN_BIT];
	assign src = {powerdown_flag, group11_flag, group10_flag,
		serial1_tx_done_flag | serial1_rx_done_flag,
		timer2_overflow_flag | timer2_external_flag,
		timer1_overflow_flag, pin_req[1], timer0_overflow_flag,
		pin_req[0]};
	assign en  = {ext_enable[MIC_PD_EN_BIT],     // [R13]
		ext_enable[MIC_G11_EN_BIT],                // [R1]
		ext_enable[MIC_G10_EN_BIT],
		core_interrupt_enable[MIC_SER1_EN_BIT],    // [R7]
		core_interrupt_enable[MIC_T2_EN_BIT],      // [R8]
		core_interrupt_enable[MIC_T1_EN_BIT],      // [R9]
		core_interrupt_enable[MIC_PIN1_EN_BIT],    // [R10]
		core_interrupt_enable[MIC_T0_EN_BIT],      // [R11]
		core_interrupt_enable[MIC_PIN0_EN_BIT]};   // [R12]
	assign pend = src & en & {MIC_SLOTS{ga}}; // [R6]

	// ------------------------------------------------------------------
	// Offer to the core; the vector is held until taken or withdrawn
	// ------------------------------------------------------------------
	logic [3:0] pick;
	assign pick = first_slot(pend); // [R16]

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= MIC_IDLE;
			held_slot   <= 4'h0;
			irq_request <= 1'b0;
			irq_vector  <= 8'h00;
			irq_number  <= 4'h0;
		end else begin
			case (state)
				MIC_IDLE: begin
					if (|pend) begin
						state       <= MIC_OFFER;
						held_slot   <= pick;
						irq_request <= 1'b1;
						irq_vector  <= MIC_VECTORS[pick*8 +: 8]; // [R1] [R13]
						irq_number  <= MIC_NUMBERS[pick*4 +: 4];
					end
				end
				MIC_OFFER: begin
					// Withdrawn if software drops the enable first
					if (irq_ack || !pend[held_slot]) begin
						state       <= MIC_IDLE;
						irq_request <= 1'b0;
					end
				end
				default: begin
					state       <= MIC_IDLE;
					irq_request <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Read-back
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sfr_rdata <= 8'h00;
		else if (sfr_rd) begin
			case (sfr_addr)
				MIC_ADDR_CORE_EN:  sfr_rdata <= core_interrupt_enable;
				MIC_ADDR_EXT_EN:   sfr_rdata <= MIC_EXT_EN_ONES
					| {3'b000, ext_enable};
				MIC_ADDR_EXT_FLAG: sfr_rdata <= MIC_EXT_FLAG_ONES
					| {group11_flag, group10_flag, 6'h00};
				MIC_ADDR_EXT_CTRL: sfr_rdata <= MIC_EXT_CTRL_ONES
					| {baud_double, 3'b000, powerdown_flag, 3'b000};
				MIC_ADDR_G4_EN:    sfr_rdata <= group4_event_enable_reg;
				MIC_ADDR_G4_FLAG:  sfr_rdata <= group4_event_flag_reg;
				MIC_ADDR_G5_EN:    sfr_rdata <= group5_event_enable_reg;
				MIC_ADDR_G5_FLAG:  sfr_rdata <= group5_event_flag_reg;
				default:           sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_ga_off2;
		!ga ##1 !ga;
	endsequence
	sequence s_offer_start;
		$rose(irq_request);
	endsequence

	a_global_block: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
		s_ga_off2 |-> !irq_request)
		else $error("request while global enable low");
	a_g11_vector: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
		irq_request && irq_number == MIC_NUM_G11 |-> irq_vector == MIC_VEC_G11)
		else $error("interrupt 11 vector wrong");
	a_pd_vector: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
		irq_request && irq_number == MIC_NUM_PD |-> irq_vector == MIC_VEC_PD)
		else $error("power-down vector wrong");
	a_pd_last: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
		s_offer_start and (irq_number == MIC_NUM_PD)
		|-> $past(pend[7:0]) == 8'h00)
		else $error("power-down chosen over a pending request");
	a_group_or: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
		group11_req |=> group11_flag)
		else $error("group request did not raise its flag");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
		group11_flag && !wr_hit(sfr_wr, sfr_addr, MIC_ADDR_EXT_FLAG)
		|=> group11_flag)
		else $error("group 11 flag dropped without software");
	a_capture_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
		capture_timer_event[1] |=> group5_event_flag_reg[1])
		else $error("capture event lost");
	a_zc_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
		!zero_cross_detect_enable && !group4_event_flag_reg[MIC_G4_ZC_BIT]
		&& !wr_hit(sfr_wr, sfr_addr, MIC_ADDR_G4_FLAG)
		|=> !group4_event_flag_reg[MIC_G4_ZC_BIT])
		else $error("zero crossing set while detector off");
	a_t1_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // [R9]
		s_offer_start and (irq_number == 4'h3)
		|-> $past(core_interrupt_enable[MIC_T1_EN_BIT]))
		else $error("timer 1 offered while disabled");
	a_ack_drop: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
		irq_request && irq_ack |=> !irq_request ##1 1'b1)
		else $error("request stayed after acknowledge");
endmodule // mic_irq_ctrl
`default_nettype wire

// ---- hw/mic_pin_catch.sv ----
// Falling-edge or low-level catcher for one interrupt pin
`timescale 1ns/1ps
`default_nettype none
module mic_pin_catch
	import mic_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Pin side
	input  wire logic pin_level,
	input  wire logic edge_mode,
	// Core side
	input  wire logic clear_req,
	output logic      fall_pulse,
	output logic      request
);
	logic prev_level;
	logic edge_latch;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			prev_level <= 1'b1;
		else
			prev_level <= pin_level;
	end

	assign fall_pulse = prev_level & ~pin_level;

	// A new edge in the acknowledge cycle survives the clear
	// Level mode keeps it empty: no stale edge after a mode change
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			edge_latch <= 1'b0;
		else if (fall_pulse && edge_mode)
			edge_latch <= 1'b1;
		else if (clear_req || !edge_mode)
			edge_latch <= 1'b0;
	end

	assign request = edge_mode ? edge_latch : ~pin_level;
endmodule // mic_pin_catch
`default_nettype wire

// ---- inc/mic_pkg.sv ----
// Constants shared by the interrupt controller files
// Function
// R1 - Interrupt 11 vectors at 5Bh, enabled by extended bit 3, flagged extended bit 7
// R2 - Capture timer overflow and captures 0-2 feed interrupt 11, bits 0-3
// R3 - Serial iface illegal data, its transmit, and comparator feed interrupt 11, bits 4-6
// R4 - Pin 3 fall, reference leakage, zero crossing at group-four bits 3-5
// R5 - Second enhanced serial events gated by its enables, group-four bit 6
// R6 - Global enable low blocks all; high defers to individual enables
// R7 - Core enable bit 6 gates first serial interrupt, transmit or receive done
// R8 - Core enable bit 5 gates timer 2 interrupt, overflow or external flag
// R9 - Core enable bit 3 gates timer 1 overflow interrupt
// R10 - Core enable bit 2 gates pin interrupt 1, falling edge or low level
// R11 - Core enable bit 1 gates timer 0 overflow interrupt
// R12 - Core enable bit 0 gates pin interrupt 0, falling edge or low level
// R13 - Power-down interrupt 12 at 63h, extended enable bit 4, control bit 3
// R14 - Group 11 flag sticks until software clears; software set raises it
// R15 - Group request is OR of each flag ANDed with its enable
// R16 - Pending requests served in polling order, interrupt 12 last
package mic_pkg;
	// ------------------------------------------------------------------
	// Register offsets on the special function port
	// ------------------------------------------------------------------
	localparam logic [7:0] MIC_ADDR_CORE_EN  = 8'hA8;
	localparam logic [7:0] MIC_ADDR_EXT_EN   = 8'hE8;
	localparam logic [7:0] MIC_ADDR_EXT_FLAG = 8'h91;
	localparam logic [7:0] MIC_ADDR_EXT_CTRL = 8'hD8;
	localparam logic [7:0] MIC_ADDR_G4_EN    = 8'h9A;
	localparam logic [7:0] MIC_ADDR_G4_FLAG  = 8'h9B;
	localparam logic [7:0] MIC_ADDR_G5_EN    = 8'h9C;
	localparam logic [7:0] MIC_ADDR_G5_FLAG  = 8'h9D;
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int MIC_GLOBAL_EN_BIT  = 7;
	localparam int MIC_SER1_EN_BIT    = 6;
	localparam int MIC_T2_EN_BIT      = 5;
	localparam int MIC_T1_EN_BIT      = 3;
	localparam int MIC_PIN1_EN_BIT    = 2;
	localparam int MIC_T0_EN_BIT      = 1;
	localparam int MIC_PIN0_EN_BIT    = 0;
	localparam int MIC_G10_EN_BIT     = 2;
	localparam int MIC_G11_EN_BIT     = 3;
	localparam int MIC_PD_EN_BIT      = 4;
	localparam int MIC_G10_FLAG_BIT   = 6;
	localparam int MIC_G11_FLAG_BIT   = 7;
	localparam int MIC_PD_FLAG_BIT    = 3;
	localparam int MIC_BAUD_DBL_BIT   = 7;
	localparam int MIC_G4_PIN3_BIT    = 3;
	localparam int MIC_G4_LEAK_BIT    = 4;
	localparam int MIC_G4_ZC_BIT      = 5;
	localparam int MIC_G4_EUART_BIT   = 6;
	// ------------------------------------------------------------------
	// Reset values and fixed read-back bits
	// ------------------------------------------------------------------
	localparam logic [7:0] MIC_RST_REG       = 8'h00;
	localparam logic [7:0] MIC_EXT_EN_ONES   = 8'hE0;
	localparam logic [7:0] MIC_EXT_FLAG_ONES = 8'h08;
	localparam logic [7:0] MIC_EXT_CTRL_ONES = 8'h40;
	// ------------------------------------------------------------------
	// Polling slots, lowest index served first
	// ------------------------------------------------------------------
	localparam int MIC_SLOTS = 9;
	localparam int MIC_SLOT_PD = 8;
	localparam logic [8*MIC_SLOTS-1:0] MIC_VECTORS = {
		8'h63, 8'h5B, 8'h53, 8'h3B, 8'h2B, 8'h1B, 8'h13, 8'h0B, 8'h03};
	localparam logic [4*MIC_SLOTS-1:0] MIC_NUMBERS = {
		4'hC, 4'hB, 4'hA, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
	localparam logic [3:0] MIC_NUM_G11 = 4'hB;
	localparam logic [3:0] MIC_NUM_PD  = 4'hC;
	localparam logic [7:0] MIC_VEC_G11 = 8'h5B;
	localparam logic [7:0] MIC_VEC_PD  = 8'h63;

	typedef enum logic [0:0] {MIC_IDLE, MIC_OFFER} mic_state_t;
endpackage

// ---- verification/mic_core_model.sv ----
// Processor core stand-in that accepts offered interrupts
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Offer from the controller
	input  wire logic       irq_request,
	input  wire logic [3:0] ack_delay,
	// Acceptance
	output logic            irq_ack
);
	logic [3:0] wait_count;

	// One-cycle ack, only on an offer that has stood ack_delay cycles
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_count <= 4'h0;
			irq_ack    <= 1'b0;
		end else if (irq_request && !irq_ack && wait_count == ack_delay) begin
			wait_count <= 4'h0;
			irq_ack    <= 1'b1;
		end else begin
			wait_count <= (irq_request && !irq_ack) ? wait_count + 4'h1 : 4'h0;
			irq_ack    <= 1'b0;
		end
	end
endmodule // mic_core_model
`default_nettype wire

// ---- verification/mic_irq_ctrl_test.sv ----
// Self-checking bench for the lower interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define check_eq(nm, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("mismatch %s expected %h seen %h", nm, e, g); \
	end \
end
module mic_irq_ctrl_test;
	logic       core_clk  = 1'b0;
	logic       rst_n     = 1'b0;
	logic       sfr_wr    = 1'b0;
	logic       sfr_rd    = 1'b0;
	logic [7:0] sfr_addr  = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] cs        = 8'h00;
	logic [13:0] ev       = 14'h0000;
	logic [4:0] gate      = 5'h00;
	logic [3:0] ack_delay = 4'h0;
	logic [7:0] sfr_rdata;
	logic [7:0] irq_vector;
	logic [3:0] irq_number;
	logic       irq_request;
	logic       irq_ack;
	int         fails = 0;
	int         checks = 0;

	always #2 core_clk = ~core_clk;

	// Pins are active low, so the bench's set bits pull them down
	mic_irq_ctrl mic_irq_ctrl_inst (
		.core_clk(core_clk), .rst_n(rst_n),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.pin_irq0_input(~cs[6]), .pin_irq1_input(~cs[7]),
		.pin0_edge_mode(gate[0]), .pin1_edge_mode(gate[1]),
		.timer0_overflow_flag(cs[0]), .timer1_overflow_flag(cs[1]),
		.timer2_overflow_flag(cs[2]), .timer2_external_flag(cs[3]),
		.serial1_tx_done_flag(cs[4]), .serial1_rx_done_flag(cs[5]),
		.pin_irq3_input(~ev[7]), .ref_leak_event(ev[8]),
		.zero_cross_event(ev[9]), .zero_cross_detect_enable(gate[2]),
		.euart_event_status(ev[12:10]), .euart_rx_irq_enable(gate[3]),
		.euart_tx_irq_enable(gate[4]), .capture_timer_event(ev[3:0]),
		.serial_iface_illegal_event(ev[4]), .serial_iface_tx_event(ev[5]),
		.comparator_event(ev[6]), .powerdown_event(ev[13]),
		.irq_ack(irq_ack), .irq_request(irq_request),
		.irq_vector(irq_vector), .irq_number(irq_number)
	);

	mic_core_model mic_core_model_inst (
		.core_clk(core_clk), .rst_n(rst_n), .irq_request(irq_request),
		.ack_delay(ack_delay), .irq_ack(irq_ack)
	);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic end_of_test;
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		tick(1);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		tick(1);
		sfr_rd = 1'b1;
		sfr_addr = a;
		tick(1);
		sfr_rd = 1'b0;
		`check_eq("sfr_rdata", e, sfr_rdata)
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			tick(1);
			`check_eq("irq_request", 1'b0, irq_request)
		end
	endtask

	task automatic offer(input logic [7:0] v, input logic [3:0] n);
		int i;
		for (i = 0; i < 20 && irq_request !== 1'b1; i++)
			tick(1);
		if (irq_request !== 1'b1) begin
			fails++;
			$display("mismatch irq_request expected 1 seen %b", irq_request);
			end_of_test;
		end
		`check_eq("irq_vector", v, irq_vector)
		`check_eq("irq_number", n, irq_number)
	endtask

	// Waits for the offer to stay down for n cycles in a row
	task automatic idle(input int n);
		int i;
		int low;
		low = 0;
		for (i = 0; i < 30 && low < n; i++) begin
			tick(1);
			low = (irq_request === 1'b0) ? low + 1 : 0;
		end
		if (low < n) begin
			fails++;
			$display("mismatch irq_request expected 0 seen %b", irq_request);
			end_of_test;
		end
	endtask

	task automatic pulse(input int k);
		tick(1);
		ev[k] = 1'b1;
		tick(1);
		ev[k] = 1'b0;
	endtask

	// Peripheral flags first, else the group flags set again at once
	task automatic clr;
		wr(8'h9d, 8'h00);
		wr(8'h9b, 8'h00);
		wr(8'h91, 8'h00);
		wr(8'hd8, 8'h00);
		idle(2);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic regs_scn;
		rd(8'ha8, 8'h00);
		rd(8'he8, 8'he0);
		rd(8'h91, 8'h08);
		rd(8'hd8, 8'h40);
		rd(8'h10, 8'h00);
		wr(8'ha8, 8'h5a);
		rd(8'ha8, 8'h5a);
		wr(8'he8, 8'h03);
		rd(8'he8, 8'he3);
		wr(8'hd8, 8'h80);
		rd(8'hd8, 8'hc0);
		wr(8'h91, 8'h07);
		rd(8'h91, 8'h08);
		wr(8'ha8, 8'h00);
	endtask

	task automatic classic_scn;
		int i;
		int eb[8] = '{1, 3, 5, 5, 6, 6, 0, 2};
		logic [7:0] vv[8] = '{8'h0b, 8'h1b, 8'h2b, 8'h2b, 8'h3b, 8'h3b,
			8'h03, 8'h13};
		logic [3:0] nn[8] = '{4'h1, 4'h3, 4'h5, 4'h5, 4'h7, 4'h7, 4'h0, 4'h2};
		for (i = 0; i < 8; i++) begin
			wr(8'ha8, 8'h01 << eb[i]);
			cs[i] = 1'b1;
			quiet(4);
			wr(8'ha8, 8'hff ^ (8'h01 << eb[i]));
			quiet(4);
			wr(8'ha8, 8'h80 | (8'h01 << eb[i]));
			offer(vv[i], nn[i]);
			cs[i] = 1'b0;
			idle(2);
		end
		// Edge mode with a slow core: the latch must outlive the pin
		ack_delay = 4'h3;
		for (i = 0; i < 2; i++) begin
			gate[i] = 1'b1;
			wr(8'ha8, 8'h80 | (8'h01 << (2 * i)));
			quiet(2);
			cs[6 + i] = 1'b1;
			tick(1);
			cs[6 + i] = 1'b0;
			offer(vv[6 + i], nn[6 + i]);
			tick(2);
			`check_eq("irq_request", 1'b1, irq_request)
			idle(2);
			quiet(4);
			gate[i] = 1'b0;
		end
		ack_delay = 4'h0;
	endtask

	task automatic group11_scn;
		int i;
		wr(8'ha8, 8'h80);
		wr(8'he8, 8'h08);
		for (i = 0; i < 7; i++) begin
			wr(8'h9c, 8'h7f ^ (8'h01 << i));
			pulse(i);
			quiet(4);
			clr;
			wr(8'h9c, 8'h01 << i);
			pulse(i);
			offer(8'h5b, 4'hb);
			rd(8'h9d, 8'h01 << i);
			rd(8'h91, 8'h88);
			clr;
		end
		wr(8'he8, 8'h00);
		wr(8'h91, 8'h80);
		quiet(4);
		rd(8'h91, 8'h88);
		wr(8'he8, 8'h08);
		offer(8'h5b, 4'hb);
		clr;
	endtask

	task automatic group10_scn;
		int k;
		int b;
		wr(8'he8, 8'h04);
		gate[4:2] = 3'b111;
		for (k = 7; k < 13; k++) begin
			b = (k < 10) ? k - 4 : 6;
			wr(8'h9a, 8'h78 ^ (8'h01 << b));
			pulse(k);
			quiet(4);
			clr;
			wr(8'h9a, 8'h01 << b);
			if (k > 8) begin
				gate[4:2] = 3'b000;
				pulse(k);
				quiet(4);
				clr;
				gate[4:2] = 3'b111;
			end
			pulse(k);
			offer(8'h53, 4'ha);
			rd(8'h9b, 8'h01 << b);
			clr;
		end
	endtask

	task automatic pd_scn;
		wr(8'he8, 8'h00);
		pulse(13);
		quiet(4);
		rd(8'hd8, 8'h48);
		wr(8'he8, 8'h10);
		offer(8'h63, 4'hc);
		clr;
		wr(8'ha8, 8'h02);
		cs[0] = 1'b1;
		pulse(13);
		quiet(4);
		wr(8'ha8, 8'h82);
		offer(8'h0b, 4'h1);
		cs[0] = 1'b0;
		idle(1);
		offer(8'h63, 4'hc);
		clr;
	endtask

	// Mid-run reset with an offer standing drops it at once
	task automatic reset_scn;
		wr(8'ha8, 8'h81);
		cs[6] = 1'b1;
		offer(8'h03, 4'h0);
		rst_n = 1'b0;
		cs[6] = 1'b0;
		tick(2);
		`check_eq("irq_request", 1'b0, irq_request)
		`check_eq("irq_vector", 8'h00, irq_vector)
		rst_n = 1'b1;
		quiet(2);
		rd(8'ha8, 8'h00);
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		regs_scn;
		classic_scn;
		group11_scn;
		group10_scn;
		pd_scn;
		reset_scn;
		end_of_test;
	end
endmodule // mic_irq_ctrl_test
`default_nettype wire
